// file: src/mlsw_top.sv
// Lane swap multiplexer and on/off mode control for the micromirror array link.
// Assumes request pins are asynchronous and the data source is on mclk.
// Notes on behaviour
// - An internal selection chooses between two lane swap configurations.
// - Option one drives array lanes 0..7 from lanes D,C,B,A,H,G,F,E.
// - Option two drives array lanes 0..7 from lanes E,F,G,H,A,B,C,D.
// - Positive and negative legs of a lane always move together.
// - Projector-on request high powers the block into ON mode.
// - Projector-on request low puts the block in OFF with outputs quiet.
// - Firmware loads from SPI flash at startup and is fetched during operation.
// - Swap selection changes only through control-link commands; on/off mode follows the projector-on request pin.
`timescale 1ns/1ps
`default_nettype none
module mlsw_top #(
    parameter int LANES = mlsw_pkg::LANE_COUNT,
    parameter int LW = mlsw_pkg::LANE_WIDTH,
    parameter int BOOT_CYCLES = mlsw_pkg::BOOT_CYCLES
) (
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              projector_on_request,
    input  wire logic [7:0]        ctrl_cmd,
    input  wire logic              ctrl_cmd_valid,
    input  wire logic [LANES*LW-1:0] src_data,
    input  wire logic              src_valid,
    output var  logic              src_ready,
    input  wire logic              src_last,
    output var  logic [LANES*LW-1:0] hs_write_data_lane_p,
    output var  logic [LANES*LW-1:0] hs_write_data_lane_n,
    output var  logic              hs_valid,
    output var  logic              hs_last,
    output var  logic              flash_cs_n,
    output var  logic              flash_sclk,
    output var  logic              flash_mosi,
    input  wire logic              flash_miso,
    output var  logic              boot_busy,
    output var  logic              swap_option2,
    output var  logic              mode_on
);
    localparam int CW = $clog2(BOOT_CYCLES + 1);
    localparam int DW = LANES * LW;

    logic          req_meta_reg;
    logic          req_sync_reg;
    logic          miso_meta_reg;
    logic          miso_sync_reg;
    mlsw_pkg::mlsw_mode_type mode_reg;
    logic [CW-1:0] boot_cnt_reg;
    logic          swap_pend_reg;
    logic          swap_active_reg;
    logic          in_frame_reg;
    logic [5:0]    sh_cnt_reg;
    logic [31:0]   sh_out_reg;
    logic [7:0]    fw_byte_reg;
    logic [23:0]   fw_words_reg;
    logic          fetch_req_reg;
    logic [DW-1:0] fifo_data;
    logic          fifo_valid;
    logic          fifo_in_ready;
    logic          fifo_out_ready;
    logic [DW-1:0] mapped;
    logic          link_idle;
    logic          flash_done;
    logic          src_last_q;
    logic [DW:0]   fifo_out_word;
    logic          take;
    logic          on_next;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
        end else begin
            req_meta_reg <= projector_on_request;
            req_sync_reg <= req_meta_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            miso_meta_reg <= 1'b0;
            miso_sync_reg <= 1'b0;
        end else begin
            miso_meta_reg <= flash_miso;
            miso_sync_reg <= miso_meta_reg;
        end
    end

    // A word taken on an edge keeps the mode in ON, so no word is stranded in the FIFO.
    assign take = src_valid && src_ready;
    assign on_next = (mode_reg == mlsw_pkg::MLSW_ON
                      && !(!take && ((!req_sync_reg && link_idle) || fetch_req_reg)))
                     || (mode_reg == mlsw_pkg::MLSW_BOOT && flash_done
                         && boot_cnt_reg == CW'(BOOT_CYCLES))
                     || (mode_reg == mlsw_pkg::MLSW_FETCH && flash_done);

    // Mode control: boot runs to completion before OFF may be taken.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= mlsw_pkg::MLSW_OFF;
            boot_cnt_reg <= '0;
        end else begin
            unique case (mode_reg)
                mlsw_pkg::MLSW_OFF: begin
                    boot_cnt_reg <= '0;
                    if (req_sync_reg) begin
                        mode_reg <= mlsw_pkg::MLSW_BOOT;
                    end
                end
                mlsw_pkg::MLSW_BOOT: begin
                    if (boot_cnt_reg != CW'(BOOT_CYCLES)) begin
                        boot_cnt_reg <= boot_cnt_reg + 1'b1;
                    end
                    if (flash_done && boot_cnt_reg == CW'(BOOT_CYCLES)) begin
                        mode_reg <= mlsw_pkg::MLSW_ON;
                    end
                end
                mlsw_pkg::MLSW_ON: begin
                    if (!take && !req_sync_reg && link_idle) begin
                        mode_reg <= mlsw_pkg::MLSW_OFF;
                    end else if (!take && fetch_req_reg) begin
                        mode_reg <= mlsw_pkg::MLSW_FETCH;
                    end
                end
                mlsw_pkg::MLSW_FETCH: begin
                    if (flash_done) begin
                        mode_reg <= mlsw_pkg::MLSW_ON;
                    end
                end
            endcase
        end
    end

    // Serial flash reader: command plus address, then image bytes.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            flash_cs_n <= 1'b1;
            flash_sclk <= 1'b0;
            flash_mosi <= 1'b0;
            sh_cnt_reg <= '0;
            sh_out_reg <= '0;
            fw_byte_reg <= '0;
            fw_words_reg <= '0;
        end else if ((mode_reg == mlsw_pkg::MLSW_BOOT || mode_reg == mlsw_pkg::MLSW_FETCH)
                     && !flash_done) begin
            if (flash_cs_n) begin
                flash_cs_n <= 1'b0;
                flash_mosi <= mlsw_pkg::FLASH_READ_CMD[7];
                sh_out_reg <= {mlsw_pkg::FLASH_READ_CMD[6:0], mlsw_pkg::IMAGE_BASE_ADDR, 1'b0};
                sh_cnt_reg <= '0;
                fw_words_reg <= '0;
            end else if (!flash_sclk) begin
                flash_sclk <= 1'b1;
                if (sh_cnt_reg >= 6'h20) begin
                    fw_byte_reg <= {fw_byte_reg[6:0], miso_sync_reg};
                end
            end else begin
                flash_sclk <= 1'b0;
                flash_mosi <= sh_out_reg[31];
                sh_out_reg <= {sh_out_reg[30:0], 1'b0};
                if (sh_cnt_reg == 6'h27) begin
                    sh_cnt_reg <= 6'h20;
                    fw_words_reg <= fw_words_reg + 24'h000001;
                end else begin
                    sh_cnt_reg <= sh_cnt_reg + 6'h01;
                end
            end
        end else begin
            flash_cs_n <= 1'b1;
            flash_sclk <= 1'b0;
            flash_mosi <= 1'b0;
            if (mode_reg == mlsw_pkg::MLSW_OFF || mode_reg == mlsw_pkg::MLSW_ON) begin
                fw_words_reg <= '0;
            end
        end
    end

    assign flash_done = (fw_words_reg == mlsw_pkg::IMAGE_WORDS);

    // Control commands: accepted only in ON mode.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            swap_pend_reg <= mlsw_pkg::SWAP_RESET;
            fetch_req_reg <= 1'b0;
        end else begin
            if (mode_reg == mlsw_pkg::MLSW_FETCH) begin
                fetch_req_reg <= 1'b0;
            end
            if (ctrl_cmd_valid && mode_reg == mlsw_pkg::MLSW_ON) begin
                unique case (ctrl_cmd)
                    mlsw_pkg::CMD_SWAP_OPT1: swap_pend_reg <= 1'b0;
                    mlsw_pkg::CMD_SWAP_OPT2: swap_pend_reg <= 1'b1;
                    mlsw_pkg::CMD_FETCH: fetch_req_reg <= 1'b1;
                    default: ;
                endcase
            end
        end
    end

    // Frame tracking and idle-only swap update.
    assign link_idle = !in_frame_reg && !fifo_valid;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_frame_reg <= 1'b0;
            swap_active_reg <= mlsw_pkg::SWAP_RESET;
        end else begin
            if (fifo_valid && fifo_out_ready) begin
                in_frame_reg <= !src_last_q;
            end
            if (link_idle) begin
                swap_active_reg <= swap_pend_reg;
            end
        end
    end

    mlsw_fifo #(
        .WIDTH (DW + 1),
        .DEPTH (mlsw_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .in_data   ({src_last, src_data}),
        .in_valid  (take),
        .in_ready  (fifo_in_ready),
        .out_data  (fifo_out_word),
        .out_valid (fifo_valid),
        .out_ready (fifo_out_ready)
    );

    assign fifo_data = fifo_out_word[DW-1:0];
    assign src_last_q = fifo_out_word[DW];
    assign fifo_out_ready = (mode_reg == mlsw_pkg::MLSW_ON);

    // Lane map: source lanes A..H are indices 0..7.
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            localparam int OPT1 = (g < LANES/2) ? (LANES/2 - 1 - g) : (LANES - 1 - (g - LANES/2));
            localparam int OPT2 = (g < LANES/2) ? (LANES/2 + g) : (g - LANES/2);
            assign mapped[g*LW +: LW] = swap_active_reg
                ? fifo_data[OPT2*LW +: LW]
                : fifo_data[OPT1*LW +: LW];
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hs_write_data_lane_p <= '0;
            hs_write_data_lane_n <= '0;
            hs_valid <= 1'b0;
            hs_last <= 1'b0;
        end else if (fifo_valid && fifo_out_ready) begin
            hs_write_data_lane_p <= mapped;
            hs_write_data_lane_n <= ~mapped;
            hs_valid <= 1'b1;
            hs_last <= src_last_q;
        end else begin
            hs_write_data_lane_p <= '0;
            hs_write_data_lane_n <= '0;
            hs_valid <= 1'b0;
            hs_last <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            src_ready <= 1'b0;
        end else begin
            src_ready <= on_next && fifo_in_ready;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            boot_busy <= 1'b0;
        end else begin
            boot_busy <= (mode_reg == mlsw_pkg::MLSW_BOOT);
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            swap_option2 <= 1'b0;
        end else begin
            swap_option2 <= swap_active_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mode_on <= 1'b0;
        end else begin
            mode_on <= (mode_reg == mlsw_pkg::MLSW_ON || mode_reg == mlsw_pkg::MLSW_FETCH);
        end
    end
endmodule : mlsw_top
`default_nettype wire

// file: src/mlsw_pkg.sv
// Package for the micromirror lane swap and power mode block.
// Assumes a single 100 MHz core clock and no software-visible registers.
package mlsw_pkg;

    localparam int LANE_COUNT = 8;
    localparam int LANE_WIDTH = 8;
    localparam int FIFO_DEPTH = 4;
    localparam int CLK_PERIOD_NS = 10;

    // Boot time taken by the firmware load, in microseconds and in cycles.
    localparam int BOOT_TIME_US = 100;
    localparam int BOOT_CYCLES = (BOOT_TIME_US * 1000) / CLK_PERIOD_NS;

    // Flash command and address width for firmware fetches.
    localparam logic [7:0] FLASH_READ_CMD = 8'h03;
    localparam int FLASH_ADDR_WIDTH = 24;
    localparam logic [23:0] IMAGE_BASE_ADDR = 24'h000000;
    localparam logic [23:0] IMAGE_WORDS = 24'h000010;

    // Control command codes received from the control link.
    localparam logic [7:0] CMD_SWAP_OPT1 = 8'h01;
    localparam logic [7:0] CMD_SWAP_OPT2 = 8'h02;
    localparam logic [7:0] CMD_FETCH = 8'h10;

    // Reset values.
    localparam logic SWAP_RESET = 1'b0;

    typedef enum logic [3:0] {
        MLSW_OFF   = 4'b0001,
        MLSW_BOOT  = 4'b0010,
        MLSW_ON    = 4'b0100,
        MLSW_FETCH = 4'b1000
    } mlsw_mode_type;

endpackage : mlsw_pkg

// file: src/mlsw_fifo.sv
// Small synchronous FIFO with valid and ready on both sides.
// Assumes both sides run on mclk.
`timescale 1ns/1ps
`default_nettype none
module mlsw_fifo #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 4
) (
    input  wire logic             mclk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output var  logic             in_ready,
    output var  logic [WIDTH-1:0] out_data,
    output var  logic             out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : mlsw_fifo
`default_nettype wire

// file: sim/mlsw_top_sva.sv
// Assertions on the ports of the lane swap block.
// Assumes one clock, mclk, and the async active-low reset rst_n.
`timescale 1ns/1ps
`default_nettype none
module mlsw_top_sva #(
    parameter int LANES = 8,
    parameter int LW    = 8
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic                src_valid,
    input wire logic                src_ready,
    input wire logic [LANES*LW-1:0] hs_write_data_lane_p,
    input wire logic [LANES*LW-1:0] hs_write_data_lane_n,
    input wire logic                hs_valid,
    input wire logic                hs_last,
    input wire logic                flash_cs_n,
    input wire logic                boot_busy,
    input wire logic                swap_option2,
    input wire logic                mode_on
);
    logic legs_ok;
    logic lanes_zero;
    assign legs_ok = (hs_write_data_lane_n == ~hs_write_data_lane_p);
    assign lanes_zero = ~|{hs_write_data_lane_p, hs_write_data_lane_n};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    a_pair_legs: assert property (hs_valid |-> legs_ok)
        else $error("n leg differs from inverted p leg");
    a_idle_quiet: assert property (!hs_valid |-> lanes_zero)
        else $error("lanes driven without a word");
    a_last_in_word: assert property (hs_last |-> hs_valid)
        else $error("last flag without a word");
    a_take_to_out: assert property (src_valid && src_ready |-> ##[2:8] hs_valid)
        else $error("taken word never reached the lanes");
    a_ready_in_on: assert property (src_ready |=> mode_on)
        else $error("source accepted outside on mode");
    a_off_no_out: assert property (!mode_on && !$past(mode_on) |-> !hs_valid)
        else $error("word sent in off mode");
    a_boot_first: assert property ($rose(mode_on) |-> $past(boot_busy))
        else $error("on mode without boot");
    a_flash_owner: assert property ($fell(flash_cs_n) |-> boot_busy || mode_on)
        else $error("flash selected in off mode");
    a_swap_idle: assert property ($changed(swap_option2) |-> !$past(hs_valid))
        else $error("mapping changed during a word");
    a_swap_frame: assert property (hs_valid && !hs_last |=> $stable(swap_option2))
        else $error("mapping changed inside a transfer");
endmodule : mlsw_top_sva
bind mlsw_top mlsw_top_sva #(.LANES(LANES), .LW(LW)) u_sva (
    .mclk(mclk), .rst_n(rst_n), .src_valid(src_valid), .src_ready(src_ready),
    .hs_write_data_lane_p(hs_write_data_lane_p),
    .hs_write_data_lane_n(hs_write_data_lane_n),
    .hs_valid(hs_valid), .hs_last(hs_last), .flash_cs_n(flash_cs_n),
    .boot_busy(boot_busy), .swap_option2(swap_option2), .mode_on(mode_on)
);
`default_nettype wire

// file: sim/mlsw_array_model.sv
// Model of the micromirror array taking the eight write-data lanes.
// Assumes the lanes are sampled on the rising edge of mclk.
`timescale 1ns/1ps
`default_nettype none
module mlsw_array_model (
    input  wire logic        mclk,
    input  wire logic [63:0] lane_p,
    input  wire logic [63:0] lane_n,
    input  wire logic        lane_valid,
    input  wire logic        lane_last,
    output var  logic [63:0] rx_data,
    output var  logic        rx_valid,
    output var  logic        rx_last,
    output var  logic        rx_pair_ok
);
    // Array lane k is bits 8k+7:8k of both legs.
    always_ff @(posedge mclk) begin
        rx_valid   <= lane_valid;
        rx_last    <= lane_last;
        rx_data    <= lane_p;
        rx_pair_ok <= (lane_n === ~lane_p);
    end
endmodule : mlsw_array_model
`default_nettype wire

// file: sim/mlsw_top_bench.sv
// Self-checking bench for the lane swap and power mode block.
// Assumes a 100 MHz mclk and a short boot count.
`timescale 1ns/1ps
`default_nettype none
module mlsw_top_bench;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        projector_on_request = 1'b0;
    logic [7:0]  ctrl_cmd = 8'h00;
    logic        cmd_valid = 1'b0;
    logic [63:0] src_data = 64'h0;
    logic        src_valid = 1'b0;
    logic        src_last = 1'b0;
    logic        flash_miso = 1'b0;
    logic        src_ready, hs_valid, hs_last, cs_n, boot_busy, swap2, mode_on;
    logic        rx_valid, rx_last, rx_ok, seen;
    logic        sclk, mosi;
    logic [7:0]  cmd_seen = 8'h00;
    int          nbits = 0;
    logic [63:0] hs_p, hs_n, rx_data;
    logic [31:0] rnd = 32'h0001054C;
    logic [64:0] exp_q[$];
    int          failures = 0;
    int          checks = 0;
    always #5 mclk = ~mclk;
    mlsw_top #(.BOOT_CYCLES(20)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .projector_on_request(projector_on_request),
        .ctrl_cmd(ctrl_cmd), .ctrl_cmd_valid(cmd_valid), .src_data(src_data),
        .src_valid(src_valid), .src_ready(src_ready), .src_last(src_last),
        .hs_write_data_lane_p(hs_p), .hs_write_data_lane_n(hs_n), .hs_valid(hs_valid),
        .hs_last(hs_last), .flash_cs_n(cs_n), .flash_sclk(sclk), .flash_mosi(mosi),
        .flash_miso(flash_miso), .boot_busy(boot_busy), .swap_option2(swap2),
        .mode_on(mode_on)
    );
    mlsw_array_model u_array (
        .mclk(mclk), .lane_p(hs_p), .lane_n(hs_n), .lane_valid(hs_valid),
        .lane_last(hs_last), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_last(rx_last), .rx_pair_ok(rx_ok)
    );
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [63:0] lane_map(logic [63:0] d, logic opt2);
        logic [63:0] m;
        for (int k = 0; k < 8; k++) begin
            m[8*k +: 8] = d[8*(opt2 ? (k + 4) % 8 : (k < 4 ? 3 - k : 11 - k)) +: 8];
        end
        return m;
    endfunction : lane_map
    task automatic chk(string nm, logic [64:0] seen_v, logic [64:0] exp_v);
        checks++;
        if (seen_v !== exp_v) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp_v, seen_v);
        end
    endtask : chk
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    task automatic send_cmd(logic [7:0] c);
        ctrl_cmd = c;
        cmd_valid = 1'b1;
        @(posedge mclk);
        #1;
        cmd_valid = 1'b0;
    endtask : send_cmd
    task automatic send_frame(int words, logic opt2, logic mid_en, logic [7:0] mid);
        int t;
        for (int w = 0; w < words; w++) begin
            src_data = {rnd, ~rnd ^ w};
            src_last = (w == words - 1);
            src_valid = 1'b1;
            cmd_valid = mid_en && w == 1;
            ctrl_cmd = mid;
            t = 0;
            do begin
                @(negedge mclk);
                t++;
            end while (src_ready !== 1'b1 && t < 200);
            @(posedge mclk);
            exp_q.push_back({src_last, lane_map(src_data, opt2)});
            #1;
            cmd_valid = 1'b0;
        end
        src_valid = 1'b0;
        src_last = 1'b0;
        repeat (12) @(posedge mclk);
        #1;
        chk("drained", {64'h0, exp_q.size() == 0}, 65'h1);
    endtask : send_frame
    always @(posedge mclk) begin
        #1;
        rnd = lfsr(rnd);
        flash_miso = rnd[7];
    end
    always @(posedge sclk) begin
        if (nbits < 8) cmd_seen = {cmd_seen[6:0], mosi};
        nbits++;
    end
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) begin
            chk("pair", {64'h0, rx_ok}, 65'h1);
            if (exp_q.size() == 0) chk("extra word", 65'h1, 65'h0);
            else chk("lanes", {rx_last, rx_data}, exp_q.pop_front());
        end
    end
    initial begin
        #200000;
        failures++;
        $display("[ERR] watchdog expected finish seen timeout");
        end_of_test();
    end
    initial begin
        repeat (5) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        send_cmd(mlsw_pkg::CMD_SWAP_OPT2);
        repeat (4) @(posedge mclk);
        #1;
        chk("swap in off", {64'h0, swap2}, 65'h0);
        chk("ready in off", {64'h0, src_ready}, 65'h0);
        $display("test off_mode done");
        seen = 1'b0;
        projector_on_request = 1'b1;
        for (int t = 0; t < 2000 && mode_on !== 1'b1; t++) begin
            @(posedge mclk);
            #1;
            if (cs_n === 1'b0 && boot_busy === 1'b1) seen = 1'b1;
        end
        chk("boot flash read", {64'h0, seen}, 65'h1);
        chk("flash command", {57'h0, cmd_seen}, {57'h0, mlsw_pkg::FLASH_READ_CMD});
        chk("mode on", {64'h0, mode_on}, 65'h1);
        send_frame(3, 1'b0, 1'b0, 8'h00);
        $display("test power_up done");
        send_cmd(mlsw_pkg::CMD_SWAP_OPT2);
        repeat (4) @(posedge mclk);
        #1;
        chk("swap two", {64'h0, swap2}, 65'h1);
        send_frame(4, 1'b1, 1'b1, mlsw_pkg::CMD_SWAP_OPT1);
        chk("swap after idle", {64'h0, swap2}, 65'h0);
        send_frame(2, 1'b0, 1'b0, 8'h00);
        $display("test swap done");
        seen = 1'b0;
        send_cmd(mlsw_pkg::CMD_FETCH);
        for (int t = 0; t < 2000 && !(seen && cs_n === 1'b1 && src_ready === 1'b1); t++) begin
            @(posedge mclk);
            #1;
            if (cs_n === 1'b0) seen = 1'b1;
        end
        chk("refetch", {64'h0, seen}, 65'h1);
        send_frame(2, 1'b0, 1'b0, 8'h00);
        $display("test refetch done");
        projector_on_request = 1'b0;
        for (int t = 0; t < 200 && mode_on !== 1'b0; t++) @(posedge mclk);
        repeat (4) @(posedge mclk);
        #1;
        chk("off quiet", {mode_on, src_ready, hs_valid, hs_p[61:0]}, 65'h0);
        $display("test power_down done");
        end_of_test();
    end
endmodule : mlsw_top_bench
`default_nettype wire
